/* core/trc_defs.svh */
`ifndef TRC_DEFS_SVH
`define TRC_DEFS_SVH

// clock and calculation step
`define TRC_CLOCK_NS      4
`define TRC_STEP_MS       5
`define TRC_STEP_NS       (`TRC_STEP_MS * 1000000)
`define TRC_STEP_CYCLES   (`TRC_STEP_NS / `TRC_CLOCK_NS)
// time constant lsb is 0.1 min = 6000 ms
`define TRC_TAU_UNIT_MS   6000
// step / tau in Q0.32, divided by the tau setting
`define TRC_COEF_NUM      ((64'h0000000100000000 * `TRC_STEP_MS) / `TRC_TAU_UNIT_MS)
`define TRC_PCT_FULL      8'h64
`define TRC_ONE_Q8        16'h0100

// register word offsets
`define TRC_REG_CTRL      8'h00
`define TRC_REG_PICKUP    8'h01
`define TRC_REG_SERVICE   8'h02
`define TRC_REG_TAU_HEAT  8'h03
`define TRC_REG_TAU_COOL  8'h04
`define TRC_REG_COLD_PCT  8'h05
`define TRC_REG_SET_TEMP  8'h06
`define TRC_REG_T_LOW     8'h07
`define TRC_REG_T_REF     8'h08
`define TRC_REG_T_HIGH    8'h09
`define TRC_REG_K_LOW     8'h0A
`define TRC_REG_K_HIGH    8'h0B
`define TRC_REG_CRV_T     8'h10
`define TRC_REG_CRV_K     8'h20
`define TRC_REG_STATE     8'h30
`define TRC_REG_AMB       8'h31
`define TRC_REG_PEAK      8'h32

// control fields
`define TRC_CTRL_SENSOR   0
`define TRC_CTRL_CURVE    1
`define TRC_CTRL_RESTART  2

// reset values
`define TRC_RST_PICKUP    16'h0100
`define TRC_RST_SERVICE   16'h0100
`define TRC_RST_TAU       16'h0064
`define TRC_RST_COLD_PCT  16'h3C00
`define TRC_RST_SET_TEMP  16'h0014
`define TRC_RST_T_LOW     16'h0000
`define TRC_RST_T_REF     16'h0028
`define TRC_RST_T_HIGH    16'h0046
`define TRC_RST_K_LOW     16'h0133
`define TRC_RST_K_HIGH    16'h00CC
`define TRC_RST_CRV_STEP  16'h000A

`endif

/* core/trc_pkg.sv */
package trc_pkg;

    // one sample set from the measurement front end
    typedef struct packed {
        logic        [15:0] cur_a;   // phase rms, Q8.8 x In
        logic        [15:0] cur_b;
        logic        [15:0] cur_c;
        logic signed [15:0] temp;    // sensor temperature, degrees
    } trc_meas_t;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        we;
        logic        re;
    } trc_bus_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_COLD,
        ST_FACTOR,
        ST_NORM,
        ST_COEF,
        ST_UPDATE
    } trc_state_t;

endpackage : trc_pkg

/* core/trc_calc.sv */
// Implementation choices: the register offsets and the strobed register port.
`include "trc_defs.svh"
module trc_calc #(
    parameter int STEP_CYCLES = `TRC_STEP_CYCLES,
    parameter int CURVE_PTS   = 10
) (
    input  wire  logic                clock,              // 250 MHz
    input  wire  logic                rst_n,              // async, active low
    input  wire  trc_pkg::trc_bus_t   bus,                // register request
    output logic [31:0]               rd_data,            // read data, next cycle
    input  wire  trc_pkg::trc_meas_t  meas,               // front end sample
    output logic [23:0]               state_pct,          // thermal state, Q16.8 %
    output logic [15:0]               ambient_factor,     // Q8.8
    output logic [15:0]               peak_phase_current, // Q8.8 x In
    output logic                      step_strobe         // one cycle per update
);

    initial begin
        // the step counter is 21 bits wide
        if (STEP_CYCLES < 300 || STEP_CYCLES > 2097152 || CURVE_PTS < 3 || CURVE_PTS > 16) begin
            $error("trc_calc: unsupported parameter");
        end
    end
    localparam int IW = 4;

    // settings
    logic                sensor_en;
    logic                curve_mode;
    logic        [15:0]  pickup;
    logic        [15:0]  service;
    logic        [15:0]  tau_heat;
    logic        [15:0]  tau_cool;
    logic        [15:0]  cold_pct;
    logic signed [15:0]  set_temp;
    logic signed [15:0]  t_low;
    logic signed [15:0]  t_ref;
    logic signed [15:0]  t_high;
    logic        [15:0]  k_low;
    logic        [15:0]  k_high;
    logic signed [15:0]  crv_t [CURVE_PTS];
    logic        [15:0]  crv_k [CURVE_PTS];

    // calculation state
    trc_pkg::trc_state_t state;
    trc_pkg::trc_state_t next_state;
    logic        [39:0]  theta;              // Q8.32 fraction of capacity
    logic        [39:0]  i2;                 // squared normalised current
    logic        [15:0]  base_k;
    logic                dn_neg;
    logic                restart_pend;
    logic                step_pend;
    logic        [20:0]  step_cnt;

    // shared serial divider
    logic        [63:0]  div_q;
    logic        [40:0]  div_rem;
    logic        [39:0]  div_den;
    logic        [6:0]   div_cnt;
    logic                div_busy;
    logic                div_done;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic [IW-1:0] count_ge(input logic [CURVE_PTS-1:0] v);
        count_ge = '0;
        for (int i = 1; i < CURVE_PTS; i++) begin
            count_ge = count_ge + IW'(v[i]);
        end
    endfunction : count_ge

    // register decode
    wire wr        = bus.we;
    wire [15:0] wd = bus.wdata[15:0];
    wire wr_ctrl   = wr && hit(bus.addr, `TRC_REG_CTRL);
    wire wr_restart = wr_ctrl && bus.wdata[`TRC_CTRL_RESTART];
    wire crv_t_sel = bus.addr[7:4] == `TRC_REG_CRV_T >> 4;
    wire crv_k_sel = bus.addr[7:4] == `TRC_REG_CRV_K >> 4;
    wire [3:0] crv_i = bus.addr[3:0];
    wire crv_ok    = 32'(crv_i) < CURVE_PTS;

    // settings write port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sensor_en  <= 1'b0;
            curve_mode <= 1'b0;
            pickup     <= `TRC_RST_PICKUP;
            service    <= `TRC_RST_SERVICE;
            tau_heat   <= `TRC_RST_TAU;
            tau_cool   <= `TRC_RST_TAU;
            cold_pct   <= `TRC_RST_COLD_PCT;
            set_temp   <= `TRC_RST_SET_TEMP;
            t_low      <= `TRC_RST_T_LOW;
            t_ref      <= `TRC_RST_T_REF;
            t_high     <= `TRC_RST_T_HIGH;
            k_low      <= `TRC_RST_K_LOW;
            k_high     <= `TRC_RST_K_HIGH;
        end else if (wr) begin
            if (wr_ctrl) begin
                sensor_en  <= bus.wdata[`TRC_CTRL_SENSOR];
                curve_mode <= bus.wdata[`TRC_CTRL_CURVE];
            end
            if (hit(bus.addr, `TRC_REG_PICKUP))   pickup   <= wd;
            if (hit(bus.addr, `TRC_REG_SERVICE))  service  <= wd;
            if (hit(bus.addr, `TRC_REG_TAU_HEAT)) tau_heat <= wd;
            if (hit(bus.addr, `TRC_REG_TAU_COOL)) tau_cool <= wd;
            if (hit(bus.addr, `TRC_REG_COLD_PCT)) cold_pct <= wd;
            if (hit(bus.addr, `TRC_REG_SET_TEMP)) set_temp <= wd;
            if (hit(bus.addr, `TRC_REG_T_LOW))    t_low    <= wd;
            if (hit(bus.addr, `TRC_REG_T_REF))    t_ref    <= wd;
            if (hit(bus.addr, `TRC_REG_T_HIGH))   t_high   <= wd;
            if (hit(bus.addr, `TRC_REG_K_LOW))    k_low    <= wd;
            if (hit(bus.addr, `TRC_REG_K_HIGH))   k_high   <= wd;
        end
    end

    // curve table, one slot per generate step
    for (genvar g = 0; g < CURVE_PTS; g++) begin : g_crv
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                crv_t[g] <= 16'(g * 10);
                crv_k[g] <= `TRC_ONE_Q8;
            end else if (wr && crv_ok && 32'(crv_i) == g) begin
                if (crv_t_sel) crv_t[g] <= wd;
                if (crv_k_sel) crv_k[g] <= wd;
            end
        end
    end

    // read mux; unmapped addresses read zero
    logic [31:0] next_rd;
    always_comb begin
        next_rd = 32'h00000000;
        case (bus.addr)
            `TRC_REG_CTRL:     next_rd = {30'h0, curve_mode, sensor_en};
            `TRC_REG_PICKUP:   next_rd = {16'h0, pickup};
            `TRC_REG_SERVICE:  next_rd = {16'h0, service};
            `TRC_REG_TAU_HEAT: next_rd = {16'h0, tau_heat};
            `TRC_REG_TAU_COOL: next_rd = {16'h0, tau_cool};
            `TRC_REG_COLD_PCT: next_rd = {16'h0, cold_pct};
            `TRC_REG_SET_TEMP: next_rd = {16'h0, set_temp};
            `TRC_REG_T_LOW:    next_rd = {16'h0, t_low};
            `TRC_REG_T_REF:    next_rd = {16'h0, t_ref};
            `TRC_REG_T_HIGH:   next_rd = {16'h0, t_high};
            `TRC_REG_K_LOW:    next_rd = {16'h0, k_low};
            `TRC_REG_K_HIGH:   next_rd = {16'h0, k_high};
            `TRC_REG_STATE:    next_rd = {8'h0, state_pct};
            `TRC_REG_AMB:      next_rd = {16'h0, ambient_factor};
            `TRC_REG_PEAK:     next_rd = {16'h0, peak_phase_current};
            default: begin
                if (crv_ok && crv_t_sel) next_rd = {16'h0, crv_t[crv_i]};
                if (crv_ok && crv_k_sel) next_rd = {16'h0, crv_k[crv_i]};
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) rd_data <= 32'h00000000;
        else        rd_data <= bus.re ? next_rd : 32'h00000000;
    end

    // largest phase current and ambient temperature source
    wire [15:0] max_ab = (meas.cur_a > meas.cur_b) ? meas.cur_a : meas.cur_b;
    wire [15:0] top_phase = (meas.cur_c > max_ab) ? meas.cur_c : max_ab;
    wire signed [15:0] amb_t = sensor_en ? meas.temp : set_temp;

    // breakpoints: CURVE_PTS-point curve or three points padded with the top one
    logic signed [15:0]    px [CURVE_PTS];
    logic        [15:0]    py [CURVE_PTS];
    logic [CURVE_PTS-1:0]  ge;
    for (genvar g = 0; g < CURVE_PTS; g++) begin : g_pt
        assign px[g] = curve_mode ? crv_t[g] :
                       (g == 0) ? t_low : (g == 1) ? t_ref : t_high;
        assign py[g] = curve_mode ? crv_k[g] :
                       (g == 0) ? k_low : (g == 1) ? `TRC_ONE_Q8 : k_high;
        assign ge[g] = amb_t >= px[g];
    end

    // segment pick; points must rise, padding repeats the top point
    wire [IW-1:0]       seg    = count_ge(ge);
    wire                seg_top = 32'(seg) == CURVE_PTS - 1;
    wire [IW-1:0]       seg_hi = seg_top ? seg : seg + IW'(1);
    wire                in_rng = ge[0] && !seg_top;
    wire signed [16:0]  dy     = 17'(py[seg_hi]) - 17'(py[seg]);
    wire signed [16:0]  dx     = 17'(px[seg_hi]) - 17'(px[seg]);
    wire signed [16:0]  off    = 17'(amb_t) - 17'(px[seg]);
    wire        [16:0]  dy_mag = dy[16] ? 17'(-dy) : dy;
    wire        [33:0]  k_prod = dy_mag * 17'(off);
    wire                k_div  = in_rng && dx > 0;
    wire        [15:0]  y_lo   = ge[0] ? py[seg] : py[0];

    // ambient factor from the interpolation quotient, clamped to 16 bits
    wire signed [17:0]  k_sum  = dn_neg ? 18'(base_k) - 18'(div_q[16:0])
                                        : 18'(base_k) + 18'(div_q[16:0]);
    wire        [15:0]  k_new  = k_sum[17] ? 16'h0000 :
                                 (k_sum[16] || div_q[63:17] != '0) ?
                                 (dn_neg ? 16'h0000 : 16'hFFFF) : k_sum[15:0];

    // pickup * service * factor, Q.16
    wire        [31:0]  ps     = pickup * service;
    wire        [47:0]  den_f  = ps * k_new;
    wire        [39:0]  den_n  = (den_f[47:8] == '0) ? 40'h1 : den_f[47:8];
    // normalised current squared, saturated
    wire        [23:0]  norm   = (div_q[63:24] != '0) ? 24'hFFFFFF : div_q[23:0];
    wire        [47:0]  sq     = norm * norm;
    wire        [39:0]  i2_new = (sq[47:40] != '0) ? 40'hFFFFFFFFFF : sq[39:0];
    wire                heat   = i2_new >= theta;
    wire        [15:0]  tau    = heat ? tau_heat : tau_cool;
    wire        [39:0]  tau_d  = (tau == '0) ? 40'h1 : 40'(tau);

    // exponential as 1 - step/tau; error is below 1e-6 per step
    wire        [31:0]  coef   = (div_q[63:32] != '0) ? 32'hFFFFFFFF : div_q[31:0];
    wire signed [40:0]  diff   = 41'(i2) - 41'(theta);
    wire signed [73:0]  upd    = diff * $signed({1'b0, coef});
    wire        [39:0]  th_new = theta + upd[71:32];
    // cold value to fraction Q8.32; rounded up so the percent reads back exactly
    wire        [63:0]  cold_n = {24'h0, cold_pct, 24'h0} + 64'h0000000000000063;

    // divider launch and operands per phase
    logic               div_go;
    logic       [63:0]  div_n;
    logic       [39:0]  div_d;
    always_comb begin
        div_go = 1'b0;
        div_n  = '0;
        div_d  = 40'h1;
        case (state)
            trc_pkg::ST_IDLE: begin
                div_go = restart_pend || step_pend;
                div_n  = restart_pend ? cold_n : (k_div ? 64'(k_prod) : '0);
                div_d  = restart_pend ? 40'(`TRC_PCT_FULL)
                                      : (k_div ? 40'(dx) : 40'h1);
            end
            trc_pkg::ST_FACTOR: begin
                div_go = div_done;
                div_n  = {24'h0, top_phase, 24'h0};
                div_d  = den_n;
            end
            trc_pkg::ST_NORM: begin
                div_go = div_done;
                div_n  = `TRC_COEF_NUM;
                div_d  = tau_d;
            end
            default: ;
        endcase
    end

    // phase sequence, each phase but ST_IDLE and ST_UPDATE ends with the divider
    always_comb begin
        next_state = state;
        case (state)
            trc_pkg::ST_IDLE:
                if (restart_pend)   next_state = trc_pkg::ST_COLD;
                else if (step_pend) next_state = trc_pkg::ST_FACTOR;
            trc_pkg::ST_COLD: if (div_done) next_state = trc_pkg::ST_IDLE;
            trc_pkg::ST_FACTOR: if (div_done) next_state = trc_pkg::ST_NORM;
            trc_pkg::ST_NORM: if (div_done) next_state = trc_pkg::ST_COEF;
            trc_pkg::ST_COEF: if (div_done) next_state = trc_pkg::ST_UPDATE;
            trc_pkg::ST_UPDATE: next_state = trc_pkg::ST_IDLE;
            default: next_state = trc_pkg::ST_IDLE;
        endcase
    end

    // restoring divider, one quotient bit per cycle
    wire [40:0] rem_sh = {div_rem[39:0], div_q[63]};
    wire        rem_ge = rem_sh >= {1'b0, div_den};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_q    <= '0;
            div_rem  <= '0;
            div_den  <= 40'h1;
            div_cnt  <= '0;
            div_busy <= 1'b0;
            div_done <= 1'b0;
        end else if (div_go) begin
            div_q    <= div_n;
            div_rem  <= '0;
            div_den  <= div_d;
            div_cnt  <= 7'h40;
            div_busy <= 1'b1;
            div_done <= 1'b0;
        end else if (div_busy) begin
            div_rem  <= rem_ge ? rem_sh - {1'b0, div_den} : rem_sh;
            div_q    <= {div_q[62:0], rem_ge};
            div_cnt  <= div_cnt - 7'h01;
            div_busy <= div_cnt != 7'h01;
            div_done <= div_cnt == 7'h01;
        end else begin
            div_done <= 1'b0;
        end
    end
    // step timer; a restart starts a fresh step period
    wire step_tick = 32'(step_cnt) == STEP_CYCLES - 1;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)                       step_cnt <= '0;
        else if (step_tick || wr_restart) step_cnt <= '0;
        else                              step_cnt <= step_cnt + 21'h1;
    end

    // pending flags; a new request wins over the take in the same cycle
    wire take = state == trc_pkg::ST_IDLE;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            restart_pend <= 1'b1;
            step_pend    <= 1'b0;
        end else begin
            restart_pend <= wr_restart || (restart_pend && !take);
            step_pend    <= step_tick || (step_pend && !(take && !restart_pend));
        end
    end
    // sample latch at step start and segment base for the factor
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            peak_phase_current <= '0;
            base_k             <= `TRC_ONE_Q8;
            dn_neg             <= 1'b0;
        end else if (take && !restart_pend && step_pend) begin
            peak_phase_current <= top_phase;
            base_k             <= y_lo;
            dn_neg             <= dy[16];
        end
    end

    // ambient factor and squared current, held for the update
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ambient_factor <= `TRC_ONE_Q8;
            i2             <= '0;
        end else begin
            if (state == trc_pkg::ST_FACTOR && div_done) ambient_factor <= k_new;
            if (state == trc_pkg::ST_NORM && div_done) i2 <= i2_new;
        end
    end

    // thermal state: written only on a step update or a restart
    wire th_ld = (state == trc_pkg::ST_UPDATE) || (state == trc_pkg::ST_COLD && div_done);
    wire [39:0] th_nx = (state == trc_pkg::ST_UPDATE) ? th_new : div_q[39:0];
    wire [47:0] pct_p = 48'(th_nx) * 48'(`TRC_PCT_FULL);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            theta       <= '0;
            state_pct   <= '0;
            step_strobe <= 1'b0;
        end else begin
            step_strobe <= th_ld;
            if (th_ld) begin
                theta     <= th_nx;
                state_pct <= pct_p[47:24];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) state <= trc_pkg::ST_IDLE;
        else        state <= next_state;
    end
endmodule : trc_calc

/* testbench/trc_calc_checker.sv */
module trc_calc_checker #(
    parameter int STEP_CYCLES = 400
) (
    input wire logic               clock,              // clock
    input wire logic               rst_n,              // async reset
    input wire trc_pkg::trc_bus_t  bus,                // register request
    input wire logic [31:0]        rd_data,            // read data
    input wire trc_pkg::trc_meas_t meas,               // front end sample
    input wire logic [23:0]        state_pct,          // thermal state
    input wire logic [15:0]        ambient_factor,     // ambient factor
    input wire logic [15:0]        peak_phase_current, // latched peak
    input wire logic               step_strobe         // update pulse
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic [15:0] max_ab;
    logic [15:0] max3;
    logic        restart_wr;
    logic [1:0]  skip;
    int          gap;

    // widest phase and restart request
    assign max_ab = (meas.cur_a > meas.cur_b) ? meas.cur_a : meas.cur_b;
    assign max3 = (max_ab > meas.cur_c) ? max_ab : meas.cur_c;
    assign restart_wr = bus.we && bus.addr == 8'h00 && bus.wdata[2];

    // a restart moves the step grid, so three strobes go untimed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap  <= 0;
            skip <= 2'h3;
        end else begin
            gap  <= step_strobe ? 0 : gap + 1;
            skip <= restart_wr ? 2'h3 : skip - 2'(step_strobe && skip != 2'h0);
        end
    end

    AST_RD_IDLE: assert property (!$past(bus.re) |-> rd_data == 32'h0)
        else $error("read data outside its slot");
    AST_STROBE_ONE: assert property (step_strobe |=> !step_strobe)
        else $error("step strobe longer than one cycle");
    AST_STATE_HOLD: assert property ($changed(state_pct) |-> ##[0:1] step_strobe)
        else $error("state moved without a step");
    AST_STEP_PERIOD: assert property (step_strobe && skip == 2'h0 |->
        gap >= STEP_CYCLES - 2 && gap <= STEP_CYCLES)
        else $error("step period off");
    AST_STEP_DUE: assert property (gap <= STEP_CYCLES + 300)
        else $error("step overdue");
    AST_PEAK_MAX: assert property ($changed(peak_phase_current) |->
        peak_phase_current == $past(max3))
        else $error("peak is not the largest phase");
    AST_PEAK_STROBE: assert property ($changed(peak_phase_current) |-> ##[1:300] step_strobe)
        else $error("peak latched without an update");
    AST_AMB_STROBE: assert property ($changed(ambient_factor) |-> ##[0:300] step_strobe)
        else $error("ambient factor moved without an update");
    AST_RESTART_LOAD: assert property (restart_wr |-> ##[1:400] step_strobe)
        else $error("restart not loaded");

    COV_RESTART: cover property (restart_wr ##[1:400] step_strobe);
    COV_TIMED: cover property (step_strobe && skip == 2'h0);
    COV_READ: cover property (bus.re ##1 rd_data != 32'h0);
endmodule : trc_calc_checker

bind trc_calc trc_calc_checker #(.STEP_CYCLES(STEP_CYCLES)) i_checker (
    .clock(clock), .rst_n(rst_n), .bus(bus), .rd_data(rd_data), .meas(meas),
    .state_pct(state_pct), .ambient_factor(ambient_factor),
    .peak_phase_current(peak_phase_current), .step_strobe(step_strobe)
);

/* testbench/trc_frontend.sv */
module trc_frontend (
    input  wire logic               clock,  // sample clock
    input  wire logic               rst_n,  // async reset
    input  wire trc_pkg::trc_meas_t target, // values the bench asks for
    output trc_pkg::trc_meas_t      meas    // sample to the block
);
    // one register stands in for the rms filter latency
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meas <= '0;
        end else begin
            meas <= target;
        end
    end
endmodule : trc_frontend

/* testbench/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 400;
    localparam int RST[12] = '{0, 16'h0100, 16'h0100, 16'h0064, 16'h0064, 16'h3C00,
                               16'h0014, 0, 16'h0028, 16'h0046, 16'h0133, 16'h00CC};
    logic               clock;
    logic               rst_n;
    trc_pkg::trc_bus_t  bus;
    logic [31:0]        rd_data;
    trc_pkg::trc_meas_t tgt;
    trc_pkg::trc_meas_t meas;
    logic [23:0]        state_pct;
    logic [15:0]        amb;
    logic [15:0]        peak;
    logic               stb;
    int                 mismatches = 0;
    int                 cmp_count = 0;
    int                 cycles = 0;
    int                 rg[128];          // settings as written
    bit                 rp = 1'b1;        // cold load pending
    longint             th, k, mx, i2;    // model, state in 2^-24 percent

    trc_frontend i_fe (.clock(clock), .rst_n(rst_n), .target(tgt), .meas(meas));
    trc_calc #(.STEP_CYCLES(STEP)) i_dut (
        .clock(clock), .rst_n(rst_n), .bus(bus), .rd_data(rd_data), .meas(meas),
        .state_pct(state_pct), .ambient_factor(amb), .peak_phase_current(peak),
        .step_strobe(stb)
    );

    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(logic [31:0] got, longint exp, int tol);
        cmp_count++;
        if ($isunknown(got) || longint'(got) > exp + tol || longint'(got) + tol < exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(int a, int v);
        @(posedge clock);
        bus <= '{addr: 8'(a), wdata: {16'h0000, 16'(v)}, we: 1'b1, re: 1'b0};
        @(posedge clock);
        bus.we <= 1'b0;
        rg[a] = (a == 0) ? v % 4 : v;
        rp = rp | (a == 0 && v[2]);
    endtask : wr

    task automatic rd(int a, int exp);
        @(posedge clock);
        bus <= '{addr: 8'(a), wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clock);
        bus.re <= 1'b0;
        #1;
        chk(rd_data, exp & 16'hFFFF, 0);
    endtask : rd

    // wait for n updates; the hang guard bounds it
    task automatic steps(int n);
        repeat (n) begin
            do begin
                @(posedge clock);
                #1;
            end while (stb !== 1'b1);
        end
    endtask : steps

    task automatic load(int pa, int pb, int pc, int n);
        @(posedge clock);
        tgt.cur_a <= 16'(pa);
        tgt.cur_b <= 16'(pb);
        tgt.cur_c <= 16'(pc);
        steps(n);
    endtask : load

    // ambient factor in 1/256, three points or the curve
    function automatic longint amb_model();
        int t;
        int n;
        int pt[10];
        int pk[10];
        t = rg[0][0] ? int'(meas.temp) : rg[6];
        n = rg[0][1] ? 10 : 3;
        for (int i = 0; i < 10; i++) begin
            pt[i] = rg[0][1] ? rg[16 + i] : rg[7 + i % 3];
            pk[i] = rg[0][1] ? rg[32 + i] : (i == 1 ? 256 : rg[10 + i / 2 % 2]);
        end
        if (t <= pt[0]) return pk[0];
        for (int i = 1; i < n; i++)
            if (t < pt[i]) return pk[i-1] + (pk[i] - pk[i-1]) * (t - pt[i-1]) / (pt[i] - pt[i-1]);
        return pk[n-1];
    endfunction : amb_model

    // model step at every update; exp(-x) taken as 1-x, step/tau = 1/(1200*tau)
    always @(negedge clock) begin
        if (rst_n === 1'b1 && stb === 1'b1) begin
            if (rp) begin
                th = longint'(rg[5]) <<< 16;
                rp = 1'b0;
            end else begin
                k = amb_model();
                mx = meas.cur_a > meas.cur_b ? meas.cur_a : meas.cur_b;
                mx = mx > meas.cur_c ? mx : meas.cur_c;
                // normalised current kept to 2^-24 so rounding does not pile up over steps
                i2 = (mx <<< 40) / (longint'(rg[1]) * rg[2] * k);
                i2 = (i2 * i2 * 100) >>> 24;
                th = th + (i2 - th) / (1200 * (i2 >= th ? rg[3] : rg[4]));
                chk(peak, mx, 0);
                chk(amb, k, 2);
            end
            chk(state_pct, th >>> 16, 6);
        end
    end

    initial begin
        void'($urandom(32'hA836));
        rst_n = 1'b0;
        bus = '0;
        tgt = '0;
        for (int a = 0; a < 12; a++) rg[a] = RST[a];
        for (int i = 0; i < 10; i++) begin
            rg[16 + i] = 10 * i;
            rg[32 + i] = 16'h0100;
        end
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        steps(1);
        for (int a = 0; a < 12; a++) rd(a, RST[a]);
        rd(8'h13, 30);
        wr(8'h40, 16'h1234);
        rd(8'h40, 0);
        wr(8'h30, 16'h0000);
        rd(8'h30, 16'h3C00);
        // heating on random currents, then cooling on the slower constant
        wr(3, 1);
        wr(4, 2);
        repeat (3) load($urandom_range(767, 128), $urandom_range(767, 128),
                        $urandom_range(767, 128), 1);
        load(0, 0, 0, 3);
        // set ambient across every segment, other pickup and service
        wr(1, 16'h0180);
        wr(2, 16'h00C0);
        foreach (RST[i]) if (i < 8) begin
            wr(6, i * 15 - 10);
            load(16'h0180, 16'h0100, 16'h0120, 1);
        end
        wr(0, 1);
        tgt.temp <= -16'sd5;
        load(16'h0100, 16'h0200, 16'h0100, 2);
        // settable curve
        for (int i = 0; i < 10; i++) wr(32 + i, 16'h00C0 + 16 * i);
        wr(8'h1A, 16'h0005);
        rd(8'h1A, 0);
        wr(0, 2);
        foreach (RST[i]) if (i < 4) begin
            wr(6, i * 33 - 4);
            load(16'h0100, 16'h0100, 16'h0100, 1);
        end
        // restart to full capacity under nominal load
        wr(0, 0);
        wr(1, 16'h0100);
        wr(2, 16'h0100);
        wr(6, 40);
        wr(5, 16'h6400);
        wr(0, 4);
        load(16'h0100, 16'h0100, 16'h0100, 4);
        chk(state_pct, 24'h006400, 0);
        report_and_stop();
    end
endmodule : tb_top
